// ==== hw/sal_pkg.sv ====
// package for the servo axis loop supervision block
// assumes one 100 MHz clock and an AHB-Lite register bus
`default_nettype none
package sal_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned TI_MIN_MS      = 100;
    localparam int unsigned TI_MAX_MS      = 5000;
    localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
    localparam logic signed [15:0] OFS_MIN_MV = -16'sd250;
    localparam logic signed [15:0] OFS_MAX_MV = 16'sd250;
    localparam int unsigned QUARTER_SH     = 2;   // span / 4
    localparam int unsigned DEF_DIV        = 100; // span / 100
    localparam int unsigned HALF_SH        = 1;
    // register byte offsets
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_TI      = 8'h04;
    localparam logic [7:0] A_OFS     = 8'h08;
    localparam logic [7:0] A_FE1     = 8'h0C;
    localparam logic [7:0] A_FE2     = 8'h10;
    localparam logic [7:0] A_RCPOS   = 8'h14;
    localparam logic [7:0] A_RCDEV   = 8'h18;
    localparam logic [7:0] A_SLMIN   = 8'h1C;
    localparam logic [7:0] A_SLMAX   = 8'h20;
    localparam logic [7:0] A_TW      = 8'h24;
    localparam logic [7:0] A_DMAX    = 8'h28;
    localparam logic [7:0] A_GAIN    = 8'h2C;
    localparam logic [7:0] A_THR     = 8'h30;
    localparam logic [7:0] A_STAT    = 8'h34;
    localparam logic [7:0] A_MASK    = 8'h38;
    localparam logic [7:0] A_LIM     = 8'h3C;
    // control bits
    localparam int unsigned C_OPEN = 0;
    localparam int unsigned C_MODE = 1; // two bits
    // status bits
    localparam int unsigned S_CRIT = 0;
    localparam int unsigned S_PREV = 1;
    localparam int unsigned S_RCAL = 2;
    localparam int unsigned NSTAT  = 3;
    typedef enum logic [1:0] {
        MODE_MANUAL, MODE_AUTO, MODE_EXTCMD, MODE_FOLLOW
    } sal_mode_type;
    typedef struct packed {
        logic signed [31:0] pos_set;
        logic signed [31:0] pos_meas;
        logic signed [31:0] speed_set;
        logic        [31:0] speed_abs;
        logic signed [15:0] loop_out_mv;
        logic               absorb;
        logic               healthy;
        logic               recal_evt;
    } sal_in_type;
    typedef struct packed {
        logic signed [15:0] setpoint_mv;
        logic        [15:0] gain;
        logic               stop_axis;
        logic               fault;
        logic               recal_do;
        logic signed [31:0] recal_value;
    } sal_out_type;
endpackage
`default_nettype wire

// ==== hw/sal_top.sv ====
// servo axis position loop supervision: integral gating, offset,
// following-error monitors, recalibration check, gain selection
// assumes inputs synchronous to clk_sys and an AHB-Lite master
//
// Functional notes
// - integral correction only when speed setpoint zero and error absorption active
// - integral correction only while axis healthy flag is 1
// - integral disabled in external command and follower modes
// - integral term added to output, accumulated only during stops
// - integral time 100..5000 ms accepted, zero disables integral
// - open-loop mode drives setpoint from offset plus held integral term, without loop output
// - output offset limited to -250..+250 mV
// - critical following error beyond threshold stops the axis
// - critical threshold 0..span/4, default travel/100, zero disables
// - preventive following error only flags a fault
// - preventive threshold 0..span/4, default travel/100, zero disables
// - recalibration position is target for measured position, zero disables
// - recalibration position kept within soft limits shrunk by tolerance
// - gain by speed: low, average, high around half and 1.5 threshold
// - offset added to loop output before driving setpoint
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`default_nettype none
module sal_top (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire sal_pkg::sal_in_type  loop_in,
    output var sal_pkg::sal_out_type loop_out,
    output logic                    irq
);
    import sal_pkg::*;

    logic [2:0]         ctrl_q, ctrl_d;
    logic [31:0]        ti_q, ti_d, thr_q, thr_d, gain_q, gain_d;
    logic signed [15:0] ofs_q, ofs_d;
    logic [31:0]        fe1_q, fe1_d, fe2_q, fe2_d, rdev_q, rdev_d, tw_q, tw_d, dmax_q, dmax_d;
    logic signed [31:0] rpos_q, rpos_d, slmin_q, slmin_d, slmax_q, slmax_d;
    logic signed [31:0] lower_travel_limit_q, lower_travel_limit_d, upper_travel_limit_q, upper_travel_limit_d;
    logic [NSTAT-1:0]   stat_q, stat_d, mask_q, mask_d;
    logic               dph_q, dph_d, dwr_q, dwr_d;
    logic [7:0]         dad_q, dad_d;
    logic [31:0]        rd_q, rd_d;
    logic               irq_q, irq_d;
    logic signed [31:0] integ_q, integ_d;
    logic [31:0]        ticnt_q, ticnt_d;
    sal_out_type        out_q, out_d;

    logic signed [31:0] ferr, fabs, span, wdat, rgap, rgap_abs;
    logic [31:0]        qspan;
    logic               integ_en, crit_hit, prev_hit, rcal_hit, rd_stat;
    logic [NSTAT-1:0]   evt;
    logic [31:0]        rmux;
    logic signed [31:0] out_sum;

    assign span  = slmax_q - slmin_q;
    assign qspan = 32'(span >>> QUARTER_SH);
    assign wdat  = $signed(hwdata);

    // monitors
    always_comb begin
        ferr = loop_in.pos_set - loop_in.pos_meas;
        fabs = (ferr < 0) ? -ferr : ferr;
        crit_hit = (fe1_q != 32'h0) && (32'(fabs) > fe1_q);
        prev_hit = (fe2_q != 32'h0) && (32'(fabs) > fe2_q);
        rgap = rpos_q - loop_in.pos_meas;
        rgap_abs = (rgap < 0) ? -rgap : rgap;
        rcal_hit = loop_in.recal_evt && (rpos_q != 32'sh0)
                 && (rdev_q != 32'h0) && (32'(rgap_abs) > rdev_q);
        evt = '0;
        evt[S_CRIT] = crit_hit;
        evt[S_PREV] = prev_hit;
        evt[S_RCAL] = rcal_hit;
    end

    // integral gating
    always_comb begin
        integ_en = (ti_q != 32'h0) && !ctrl_q[C_OPEN]
                 && (loop_in.speed_set == 32'sh0) && loop_in.absorb
                 && loop_in.healthy
                 && (sal_mode_type'(ctrl_q[C_MODE+:2]) != MODE_EXTCMD)
                 && (sal_mode_type'(ctrl_q[C_MODE+:2]) != MODE_FOLLOW);
        ticnt_d = ticnt_q;
        integ_d = integ_q;
        if (integ_en) begin
            if (ticnt_q >= ti_q) begin
                ticnt_d = 32'h0;
                if (ferr > 0) integ_d = integ_q + 32'sh1;
                else if (ferr < 0) integ_d = integ_q - 32'sh1;
            end else begin
                ticnt_d = ticnt_q + 32'h1;
            end
        end
    end

    // drive output
    always_comb begin
        out_d = out_q;
        out_sum = (ctrl_q[C_OPEN] ? 32'sh0 : 32'(loop_in.loop_out_mv))
                + 32'(ofs_q) + integ_q;
        out_d.setpoint_mv = out_sum[15:0];
        if (loop_in.speed_abs >= ((thr_q * 3) >> HALF_SH))
            out_d.gain = gain_q[15:0];
        else if (loop_in.speed_abs >= (thr_q >> HALF_SH))
            out_d.gain = 16'((32'(gain_q[15:0]) + 32'(gain_q[31:16])) >> HALF_SH);
        else
            out_d.gain = gain_q[31:16];
        out_d.stop_axis   = crit_hit;
        out_d.fault       = crit_hit | prev_hit;
        out_d.recal_do    = rcal_hit;
        out_d.recal_value = rpos_q;
    end

    // bus slave
    always_comb begin
        dph_d = hsel && hready && htrans[1];
        dwr_d = hwrite;
        dad_d = haddr[7:0];
        ctrl_d = ctrl_q; ti_d = ti_q; ofs_d = ofs_q; fe1_d = fe1_q; fe2_d = fe2_q;
        rpos_d = rpos_q; rdev_d = rdev_q; slmin_d = slmin_q; slmax_d = slmax_q;
        tw_d = tw_q; dmax_d = dmax_q; gain_d = gain_q; thr_d = thr_q; mask_d = mask_q;
        lower_travel_limit_d = lower_travel_limit_q; upper_travel_limit_d = upper_travel_limit_q;
        if (dph_q && dwr_q) begin
            case (dad_q)
                A_CTRL:  ctrl_d = hwdata[2:0];
                A_TI:    if (hwdata == 32'h0 || (hwdata >= TI_MIN_MS && hwdata <= TI_MAX_MS))
                             ti_d = hwdata * CYC_PER_MS;
                A_OFS:   if (wdat >= 32'(OFS_MIN_MV) && wdat <= 32'(OFS_MAX_MV))
                             ofs_d = hwdata[15:0];
                A_FE1:   if (hwdata <= qspan) fe1_d = hwdata;
                A_FE2:   if (hwdata <= qspan) fe2_d = hwdata;
                A_RCPOS: if (wdat == 32'sh0 || (wdat >= slmin_q + $signed(tw_q)
                             && wdat <= slmax_q - $signed(tw_q)))
                             rpos_d = wdat;
                A_RCDEV: if (hwdata <= (dmax_q >> HALF_SH)) rdev_d = hwdata;
                A_SLMIN: slmin_d = wdat;
                A_SLMAX: slmax_d = wdat;
                A_TW:    tw_d = hwdata;
                A_DMAX:  dmax_d = hwdata;
                A_GAIN:  gain_d = hwdata;
                A_THR:   thr_d = hwdata;
                A_MASK:  mask_d = hwdata[NSTAT-1:0];
                A_LIM: begin
                    lower_travel_limit_d = slmin_q;
                    upper_travel_limit_d = slmax_q;
                    // travel limits latched, defaults derived from them
                    fe1_d  = 32'((slmax_q - slmin_q) / DEF_DIV);
                    fe2_d  = 32'((slmax_q - slmin_q) / DEF_DIV);
                    rpos_d = ((slmax_q - slmin_q) >>> QUARTER_SH) + slmin_q;
                end
                default: ;
            endcase
        end
        case (haddr[7:0])
            A_CTRL:  rmux = 32'(ctrl_q);
            A_TI:    rmux = ti_q;
            A_OFS:   rmux = 32'(ofs_q);
            A_FE1:   rmux = fe1_q;
            A_FE2:   rmux = fe2_q;
            A_RCPOS: rmux = rpos_q;
            A_RCDEV: rmux = rdev_q;
            A_SLMIN: rmux = slmin_q;
            A_SLMAX: rmux = slmax_q;
            A_TW:    rmux = tw_q;
            A_DMAX:  rmux = dmax_q;
            A_GAIN:  rmux = gain_q;
            A_THR:   rmux = thr_q;
            A_STAT:  rmux = 32'(stat_q);
            A_MASK:  rmux = 32'(mask_q);
            A_LIM:   rmux = 32'(integ_q);
            default: rmux = 32'h0;
        endcase
        rd_stat = dph_d && !hwrite && (haddr[7:0] == A_STAT);
        rd_d = dph_d && !hwrite ? rmux : rd_q;
        // set wins over read clear
        stat_d = (rd_stat ? '0 : stat_q) | evt;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0; ti_q <= 32'h0; ofs_q <= 16'sh0; fe1_q <= 32'h0; fe2_q <= 32'h0;
            rpos_q <= 32'sh0; rdev_q <= 32'h0; slmin_q <= 32'sh0; slmax_q <= 32'sh0;
            tw_q <= 32'h0; dmax_q <= 32'h0; gain_q <= 32'h0; thr_q <= 32'h0;
            lower_travel_limit_q <= 32'sh0; upper_travel_limit_q <= 32'sh0;
            stat_q <= '0; mask_q <= '0; dph_q <= 1'b0; dwr_q <= 1'b0; dad_q <= 8'h0;
            rd_q <= 32'h0; irq_q <= 1'b0; integ_q <= 32'sh0; ticnt_q <= 32'h0;
            out_q <= '0;
        end else begin
            ctrl_q <= ctrl_d; ti_q <= ti_d; ofs_q <= ofs_d; fe1_q <= fe1_d; fe2_q <= fe2_d;
            rpos_q <= rpos_d; rdev_q <= rdev_d; slmin_q <= slmin_d; slmax_q <= slmax_d;
            tw_q <= tw_d; dmax_q <= dmax_d; gain_q <= gain_d; thr_q <= thr_d;
            lower_travel_limit_q <= lower_travel_limit_d; upper_travel_limit_q <= upper_travel_limit_d;
            stat_q <= stat_d; mask_q <= mask_d; dph_q <= dph_d; dwr_q <= dwr_d;
            dad_q <= dad_d; rd_q <= rd_d; irq_q <= irq_d; integ_q <= integ_d;
            ticnt_q <= ticnt_d; out_q <= out_d;
        end
    end

    assign hrdata    = rd_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign loop_out  = out_q;
    assign irq       = irq_q;

    property p_crit_stop;
        @(posedge clk_sys) disable iff (!rst_n) crit_hit |=> loop_out.stop_axis;
    endproperty
    a_crit_stop: assert property (p_crit_stop) else $error("critical error did not stop");
    property p_prev_nostop;
        @(posedge clk_sys) disable iff (!rst_n)
            (prev_hit && !crit_hit) |=> (loop_out.fault && !loop_out.stop_axis);
    endproperty
    a_prev_nostop: assert property (p_prev_nostop) else $error("preventive error misflagged");
    property p_fe1_zero;
        @(posedge clk_sys) disable iff (!rst_n) (fe1_q == 32'h0) |=> !loop_out.stop_axis;
    endproperty
    a_fe1_zero: assert property (p_fe1_zero) else $error("zero critical threshold checked");
    property p_fe2_zero;
        @(posedge clk_sys) disable iff (!rst_n)
            ((fe1_q == 32'h0) && (fe2_q == 32'h0)) |=> !loop_out.fault;
    endproperty
    a_fe2_zero: assert property (p_fe2_zero) else $error("zero preventive threshold checked");
    property p_integ_hold;
        @(posedge clk_sys) disable iff (!rst_n) !integ_en |=> $stable(integ_q);
    endproperty
    a_integ_hold: assert property (p_integ_hold) else $error("integral moved while disabled");
    property p_ext_noint;
        @(posedge clk_sys) disable iff (!rst_n)
            ((sal_mode_type'(ctrl_q[C_MODE+:2]) == MODE_EXTCMD)
             || (sal_mode_type'(ctrl_q[C_MODE+:2]) == MODE_FOLLOW)) |=> $stable(integ_q);
    endproperty
    a_ext_noint: assert property (p_ext_noint) else $error("integral in external mode");
    property p_unhealthy;
        @(posedge clk_sys) disable iff (!rst_n) !loop_in.healthy |=> $stable(integ_q);
    endproperty
    a_unhealthy: assert property (p_unhealthy) else $error("integral while unhealthy");
    property p_ofs_range;
        @(posedge clk_sys) disable iff (!rst_n) (ofs_q >= OFS_MIN_MV) && (ofs_q <= OFS_MAX_MV);
    endproperty
    a_ofs_range: assert property (p_ofs_range) else $error("offset out of range");
    property p_moving_noint;
        @(posedge clk_sys) disable iff (!rst_n)
            (loop_in.speed_set != 32'sh0) |=> $stable(integ_q);
    endproperty
    a_moving_noint: assert property (p_moving_noint) else $error("integral while moving");
endmodule
`default_nettype wire

// ==== tb/sal_drive_model.sv ====
// drive model: integrates the setpoint_mv output into the measured position
// assumes clk_sys and rst_n of the block; load pins the position to a known value
`default_nettype none
module sal_drive_model #(
    parameter int STEP_DIV = 1
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic signed [15:0] setpoint_mv,
    input  wire logic               stop_axis,
    input  wire logic               load,
    input  wire logic signed [31:0] load_val,
    output logic signed [31:0]      pos_meas
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned div_q;
    // slow drive: moves only every STEP_DIV cycles, halts while stopped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_meas <= '0;
            div_q    <= 0;
        end else if (load) begin
            pos_meas <= load_val;
        end else if (!stop_axis) begin
            div_q <= (div_q + 1) % STEP_DIV;
            if (div_q == 0) begin
                pos_meas <= pos_meas + 32'(setpoint_mv);
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_servo_axis_loop_supervision.sv ====
// testbench of the servo axis loop supervision block
// assumes sal_top with an AHB-Lite slave whose hreadyout feeds hready
`default_nettype none
module test_servo_axis_loop_supervision;
    timeunit 1ns;
    timeprecision 1ps;
    import sal_pkg::*;
    logic               clk_sys, rst_n, hsel, hwrite, load, hreadyout, hresp, irq;
    logic        [31:0] haddr, hwdata, hrdata, rd;
    logic        [1:0]  htrans;
    logic        [2:0]  hsize;
    logic signed [31:0] load_val, pos_meas;
    sal_in_type         li, loop_in;
    sal_out_type        loop_out;
    int                 fails, num_checks;
    always_comb begin
        loop_in          = li;
        loop_in.pos_meas = pos_meas;
    end
    sal_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .loop_in(loop_in), .loop_out(loop_out), .irq(irq));
    sal_drive_model #(.STEP_DIV(2)) drive (.clk_sys(clk_sys), .rst_n(rst_n),
        .setpoint_mv(loop_out.setpoint_mv), .stop_axis(loop_out.stop_axis),
        .load(load), .load_val(load_val), .pos_meas(pos_meas));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    // measured position lands one edge after load, so the setpoint follows it
    task automatic setpos(input int s, input int m);
        load_val   <= m;
        cyc(1);
        li.pos_set <= s;
        cyc(3);
    endtask
    task automatic t_limits();
        wr(A_SLMIN, 32'h00000000);
        wr(A_SLMAX, 32'h00009C40);
        wr(A_TW, 32'h00000064);
        wr(A_DMAX, 32'h000000C8);
        wr(A_LIM, 32'h00000001);
        rdc(A_FE1, 32'h00000190);
        rdc(A_FE2, 32'h00000190);
        rdc(A_RCPOS, 32'h00002710);
        rdc(A_LIM, 32'h00000000);
        rdc(8'h40, 32'h00000000);
        for (int m = 0; m < 4; m++) begin
            wr(A_CTRL, 32'(m << 1));
            rdc(A_CTRL, 32'(m << 1));
        end
        wr(A_CTRL, 32'h00000000);
        $display("test limits done");
    endtask
    task automatic t_ti();
        wr(A_TI, 32'h00000063);
        rdc(A_TI, 32'h00000000);
        wr(A_TI, 32'h00001389);
        rdc(A_TI, 32'h00000000);
        wr(A_TI, 32'h00000064);
        rdc(A_TI, 32'h00989680);
        li.healthy   <= 1'b1;
        li.absorb    <= 1'b1;
        li.speed_set <= 32'sd5;
        cyc(4);
        rdc(A_LIM, 32'h00000000);
        li.healthy   <= 1'b0;
        li.absorb    <= 1'b0;
        li.speed_set <= 32'sh0;
        wr(A_TI, 32'h00000000);
        rdc(A_TI, 32'h00000000);
        $display("test integral time done");
    endtask
    task automatic t_fe();
        wr(A_FE1, 32'h00000000);
        wr(A_FE2, 32'h00000000);
        setpos(1000, -9000);
        chk(32'(loop_out.stop_axis), 32'h0);
        chk(32'(loop_out.fault), 32'h0);
        setpos(1000, 1000);
        wr(A_FE1, 32'h00002711);
        rdc(A_FE1, 32'h00000000);
        wr(A_FE1, 32'h00000320);
        wr(A_FE2, 32'h00000190);
        setpos(1000, 600);
        chk(32'(loop_out.fault), 32'h0);
        setpos(1000, 599);
        chk(32'(loop_out.fault), 32'h1);
        chk(32'(loop_out.stop_axis), 32'h0);
        setpos(1000, 1801);
        chk(32'(loop_out.stop_axis), 32'h1);
        wr(A_MASK, 32'h00000002);
        cyc(2);
        chk(32'(irq), 32'h1);
        wr(A_MASK, 32'h00000000);
        cyc(2);
        chk(32'(irq), 32'h0);
        setpos(1000, 1000);
        rdc(A_STAT, 32'h00000003);
        rdc(A_STAT, 32'h00000000);
        $display("test following error done");
    endtask
    task automatic t_recal();
        wr(A_RCPOS, 32'h00000032);
        rdc(A_RCPOS, 32'h00002710);
        wr(A_RCPOS, 32'h00009C0E);
        rdc(A_RCPOS, 32'h00002710);
        wr(A_RCPOS, 32'h00001388);
        wr(A_RCDEV, 32'h00000032);
        wr(A_RCDEV, 32'h00000065);
        rdc(A_RCDEV, 32'h00000032);
        li.recal_evt <= 1'b1;
        setpos(5060, 5060);
        chk(32'(loop_out.recal_do), 32'h1);
        chk(loop_out.recal_value, 32'h00001388);
        setpos(5040, 5040);
        chk(32'(loop_out.recal_do), 32'h0);
        wr(A_RCDEV, 32'h00000000);
        setpos(5060, 5060);
        chk(32'(loop_out.recal_do), 32'h0);
        li.recal_evt <= 1'b0;
        cyc(2);
        rdc(A_STAT, 32'h00000004);
        $display("test recalibration done");
    endtask
    task automatic t_gain();
        int sp[4];
        logic [31:0] g[4];
        sp = '{400, 500, 1499, 1500};
        g  = '{32'h0100, 32'h0180, 32'h0180, 32'h0200};
        wr(A_GAIN, 32'h01000200);
        wr(A_THR, 32'h000003E8);
        for (int i = 0; i < 4; i++) begin
            li.speed_abs <= sp[i];
            cyc(3);
            chk({16'h0000, loop_out.gain}, g[i]);
        end
        $display("test gain done");
    endtask
    task automatic t_offset();
        wr(A_FE1, 32'h00000000);
        wr(A_FE2, 32'h00000000);
        wr(A_OFS, 32'h000000FB);
        rdc(A_OFS, 32'h00000000);
        wr(A_OFS, 32'hFFFFFF05);
        rdc(A_OFS, 32'h00000000);
        wr(A_OFS, 32'hFFFFFF06);
        load           <= 1'b0;
        li.loop_out_mv <= 16'sd1000;
        cyc(3);
        chk({16'h0000, loop_out.setpoint_mv}, 32'h02EE);
        wr(A_CTRL, 32'h00000001);
        wr(A_OFS, 32'h000000FA);
        // loop output still present: open loop must drop it
        li.loop_out_mv <= 16'sd1000;
        cyc(3);
        chk({16'h0000, loop_out.setpoint_mv}, 32'h00FA);
        $display("test offset done");
    endtask
    initial begin
        #200_000;
        fails++;
        complete_run();
    end
    initial begin
        fails = 0;
        num_checks = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        li = '0;
        load = 1'b1;
        load_val = '0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        t_limits();
        t_ti();
        t_fe();
        t_recal();
        t_gain();
        t_offset();
        complete_run();
    end
endmodule
`default_nettype wire
